// file: common/gcs_pkg.sv
`default_nettype none
package gcs_pkg;
  // ************************************
  // Register map
  // ************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] INTPIN_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] STRAP_OFS = 8'h0C;
  localparam int RST_SYNC_STAGES = 2;
  // ************************************
  // Rate families, base clock in kHz
  // ************************************
  localparam logic [11:0] SDH_BASE_KHZ = 12'h800;
  localparam logic [11:0] SONET_BASE_KHZ = 12'h608;
  // ************************************
  // Field layouts
  // ************************************
  typedef struct packed {
    logic pin4_output_value;
    logic pin4_direction;
    logic lock_indicator_enable;
    logic reference_fail_pin_enable;
    logic digital_freq_select_two;
    logic digital_freq_select_one;
    logic rate_family;
    logic external_switch_mode;
  } ctrl_s;
  localparam ctrl_s CTRL_RST = 8'h00;
  typedef struct packed {
    logic gp_value;
    logic gp_mode;
    logic open_drain;
    logic active_high;
    logic loss_mode;
  } int_cfg_s;
  localparam int_cfg_s INT_CFG_RST = 5'h00;
  typedef struct packed {
    logic [1:0] ref_index;
    logic selected_active;
    logic pll_locked;
    logic reference_fail;
    logic pin4_level;
  } stat_s;
  localparam stat_s STAT_RST = 6'h00;
  typedef struct packed {
    logic rate;
    logic src;
  } strap_s;
  localparam strap_s STRAP_RST = 2'h0;
endpackage : gcs_pkg
`default_nettype wire

// file: src/gcs_reset_sync.sv
`default_nettype none
module gcs_reset_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic rst_b_out
);
  logic [gcs_pkg::RST_SYNC_STAGES-1:0] stage_r;

  // Async assert, clocked release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[gcs_pkg::RST_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_b_out = stage_r[gcs_pkg::RST_SYNC_STAGES-1];
endmodule : gcs_reset_sync
`default_nettype wire

// file: src/gcs_ref_select.sv
`default_nettype none
module gcs_ref_select (
  input wire logic ext_mode_in,
  input wire logic switch_in,
  input wire logic pair_sel_in,
  input wire logic [1:0] auto_index_in,
  input wire logic [3:0] active_in,
  input wire logic [3:0] freq_ok_in,
  output logic [1:0] index_out,
  output logic active_out,
  output logic healthy_out
);
  // Index 0..3 = inputs three, four, five, six
  always_comb begin
    if (ext_mode_in) begin
      index_out = {pair_sel_in, switch_in};
    end else begin
      index_out = auto_index_in;
    end
    active_out = active_in[index_out];
    healthy_out = active_in[index_out] & freq_ok_in[index_out];
  end
endmodule : gcs_ref_select
`default_nettype wire

// file: src/gcs_top.sv
// Our own choices: the APB register port and the placing of the registers.
`default_nettype none
// How it works
// - Low reset asynchronously clears all logic except base frequency, which loads SDH
// - Switch input latched into external mode
// - External mode picks three/four or five/six
// - Strap sets rate and both frequency bits
// - Strap zero SDH, one SONET
// - Strap pin becomes general I/O afterwards
// - Fail pin follows status or floats
// - Lock pin shows lock or drives low
// - Loss bit picks interrupt or loss
// - Interrupt polarity, drive type, general output
// - Loss mode shows selected activity live
// - Fail status follows selected input monitors
// - Output five defaults from strap rate
module gcs_top (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fast_source_switch_in,
  input wire logic general_io_four_in,
  output logic general_io_four_out,
  output logic general_io_four_oe_out,
  input wire logic [3:0] ref_active_in,
  input wire logic [3:0] ref_freq_ok_in,
  input wire logic [1:0] auto_ref_index_in,
  input wire logic pair_sel_in,
  input wire logic pll_locked_in,
  input wire logic irq_event_in,
  output logic reference_fail_out,
  output logic reference_fail_oe_out,
  output logic lock_out,
  output logic interrupt_request_out,
  output logic interrupt_request_oe_out,
  output logic [1:0] selected_ref_out,
  output logic rate_family_out,
  output logic [11:0] base_freq_khz_out,
  output logic clk5_sonet_out
);
  logic rst_sync_b;
  logic strap_done_r;
  gcs_pkg::strap_s strap_r;
  gcs_pkg::ctrl_s ctrl_r;
  gcs_pkg::int_cfg_s int_cfg_r;
  gcs_pkg::stat_s stat_r;
  logic ref_fail_r;
  logic [1:0] sel_index;
  logic sel_active;
  logic sel_healthy;
  logic setup;
  logic wr_en;
  logic map_hit;
  logic [31:0] rd_nxt;
  logic int_req;
  logic int_level;

  // ************************************
  // Reset release
  // ************************************
  gcs_reset_sync u_rst (
    .clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .rst_b_out(rst_sync_b)
  );

  // ************************************
  // Strap capture at release
  // ************************************
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_done_r <= 1'b0;
      strap_r <= gcs_pkg::STRAP_RST;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      strap_r <= {general_io_four_in, fast_source_switch_in};
    end
  end

  // ************************************
  // APB slave
  // ************************************
  assign setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == gcs_pkg::CTRL_OFS) || (a == gcs_pkg::INTPIN_OFS) ||
                (a == gcs_pkg::STAT_OFS) || (a == gcs_pkg::STRAP_OFS);
  endfunction : is_mapped

  assign map_hit = is_mapped(paddr_in);

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (paddr_in)
      gcs_pkg::CTRL_OFS: rd_nxt[7:0] = ctrl_r;
      gcs_pkg::INTPIN_OFS: rd_nxt[4:0] = int_cfg_r;
      gcs_pkg::STAT_OFS: rd_nxt[5:0] = stat_r;
      gcs_pkg::STRAP_OFS: rd_nxt[1:0] = strap_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !map_hit;
      if (setup) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  // ************************************
  // Control registers
  // ************************************
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_r <= gcs_pkg::CTRL_RST;
    end else if (!strap_done_r) begin
      ctrl_r.external_switch_mode <= fast_source_switch_in;
      ctrl_r.rate_family <= general_io_four_in;
      ctrl_r.digital_freq_select_one <= general_io_four_in;
      ctrl_r.digital_freq_select_two <= general_io_four_in;
    end else if (wr_en && paddr_in == gcs_pkg::CTRL_OFS) begin
      ctrl_r <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      int_cfg_r <= gcs_pkg::INT_CFG_RST;
    end else if (wr_en && paddr_in == gcs_pkg::INTPIN_OFS) begin
      int_cfg_r <= pwdata_in[4:0];
    end
  end

  // ************************************
  // Reference selection and status
  // ************************************
  gcs_ref_select u_sel (
    .ext_mode_in(ctrl_r.external_switch_mode && strap_done_r),
    .switch_in(fast_source_switch_in),
    .pair_sel_in(pair_sel_in),
    .auto_index_in(auto_ref_index_in),
    .active_in(ref_active_in),
    .freq_ok_in(ref_freq_ok_in),
    .index_out(sel_index),
    .active_out(sel_active),
    .healthy_out(sel_healthy)
  );

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ref_fail_r <= 1'b0;
      selected_ref_out <= 2'h0;
    end else begin
      ref_fail_r <= !sel_healthy;
      selected_ref_out <= sel_index;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stat_r <= gcs_pkg::STAT_RST;
    end else begin
      stat_r <= {sel_index, sel_active, pll_locked_in, ref_fail_r, general_io_four_in};
    end
  end

  // ************************************
  // Rate family outputs
  // ************************************
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rate_family_out <= 1'b0;
      base_freq_khz_out <= gcs_pkg::SDH_BASE_KHZ;
      clk5_sonet_out <= 1'b0;
    end else begin
      rate_family_out <= ctrl_r.rate_family;
      base_freq_khz_out <= ctrl_r.rate_family ? gcs_pkg::SONET_BASE_KHZ : gcs_pkg::SDH_BASE_KHZ;
      clk5_sonet_out <= ctrl_r.digital_freq_select_two;
    end
  end

  // ************************************
  // Pin drivers
  // ************************************
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      general_io_four_out <= 1'b0;
      general_io_four_oe_out <= 1'b0;
    end else begin
      general_io_four_out <= ctrl_r.pin4_output_value;
      general_io_four_oe_out <= strap_done_r && ctrl_r.pin4_direction;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reference_fail_out <= 1'b0;
      reference_fail_oe_out <= 1'b0;
      lock_out <= 1'b0;
    end else begin
      reference_fail_out <= ref_fail_r;
      reference_fail_oe_out <= ctrl_r.reference_fail_pin_enable;
      lock_out <= ctrl_r.lock_indicator_enable && pll_locked_in;
    end
  end

  assign int_req = int_cfg_r.gp_mode ? int_cfg_r.gp_value : irq_event_in;
  assign int_level = int_cfg_r.active_high ? int_req : !int_req;

  // Outside loss mode, open drain only pulls low
  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      interrupt_request_out <= 1'b0;
      interrupt_request_oe_out <= 1'b0;
    end else if (int_cfg_r.loss_mode) begin
      interrupt_request_out <= !sel_active;
      interrupt_request_oe_out <= 1'b1;
    end else begin
      interrupt_request_out <= int_cfg_r.open_drain ? 1'b0 : int_level;
      interrupt_request_oe_out <= !int_cfg_r.open_drain || !int_level;
    end
  end

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_sync_b);

  property p_strap_hold;
    strap_done_r |=> $stable(strap_r) && strap_done_r;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_src_capture;
    $rose(strap_done_r) |-> ctrl_r.external_switch_mode == $past(fast_source_switch_in);
  endproperty
  a_src_capture: assert property (p_src_capture) else $error("switch strap lost");

  property p_rate_capture;
    $rose(strap_done_r) |-> ctrl_r.rate_family == $past(general_io_four_in) &&
      ctrl_r.digital_freq_select_one == ctrl_r.rate_family &&
      ctrl_r.digital_freq_select_two == ctrl_r.rate_family && !int_cfg_r.loss_mode;
  endproperty
  a_rate_capture: assert property (p_rate_capture) else $error("rate strap lost");

  property p_rate_decode;
    rate_family_out == (base_freq_khz_out == gcs_pkg::SONET_BASE_KHZ);
  endproperty
  a_rate_decode: assert property (p_rate_decode) else $error("rate decode wrong");

  property p_ext_switch;
    strap_done_r && ctrl_r.external_switch_mode |=>
      selected_ref_out == {$past(pair_sel_in), $past(fast_source_switch_in)};
  endproperty
  a_ext_switch: assert property (p_ext_switch) else $error("external pick wrong");

  property p_fail_pin;
    ctrl_r.reference_fail_pin_enable ##1 ctrl_r.reference_fail_pin_enable |=>
      reference_fail_oe_out && reference_fail_out == !$past(sel_healthy, 2);
  endproperty
  a_fail_pin: assert property (p_fail_pin) else $error("fail pin wrong");

  property p_fail_float;
    !ctrl_r.reference_fail_pin_enable |=> !reference_fail_oe_out;
  endproperty
  a_fail_float: assert property (p_fail_float) else $error("fail pin driven");

  property p_lock_pin;
    ctrl_r.lock_indicator_enable |=> lock_out == $past(pll_locked_in);
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");

  property p_lock_low;
    !ctrl_r.lock_indicator_enable |=> !lock_out;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock pin not low");

  property p_loss_mode;
    int_cfg_r.loss_mode |=> interrupt_request_oe_out && interrupt_request_out == !$past(sel_active);
  endproperty
  a_loss_mode: assert property (p_loss_mode) else $error("loss pin wrong");

  property p_open_drain;
    !int_cfg_r.loss_mode && int_cfg_r.open_drain |=> !(interrupt_request_oe_out && interrupt_request_out);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_gpio_drive;
    strap_done_r && ctrl_r.pin4_direction |=>
      general_io_four_oe_out && general_io_four_out == $past(ctrl_r.pin4_output_value);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("pin four not driven");

  c_ext_mode: cover property (strap_done_r && ctrl_r.external_switch_mode ##1 $changed(selected_ref_out));
  c_loss_mode: cover property (int_cfg_r.loss_mode ##1 $fell(interrupt_request_out));
  c_fail_pin: cover property ($rose(reference_fail_out) && reference_fail_oe_out);
  c_slverr: cover property (pslverr_out && pready_out);
endmodule : gcs_top
`default_nettype wire

// file: tb/gcs_board_model.sv
`default_nettype none
// ************************************
// Board side of the shared pins
// ************************************
module gcs_board_model (
  input wire logic gio_out_in,
  input wire logic gio_oe_in,
  input wire logic drv_en_in,
  input wire logic drv_val_in,
  input wire logic irq_out_in,
  input wire logic irq_oe_in,
  output logic gio_level_out,
  output logic irq_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device drive wins, then board driver, else pull-down
  assign gio_level_out = gio_oe_in ? gio_out_in : (drv_en_in ? drv_val_in : 1'h0);
  // Board pull-up on the request line
  assign irq_level_out = irq_oe_in ? irq_out_in : 1'h1;
endmodule : gcs_board_model
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctl;
    logic [4:0] icf;
    logic [1:0] ps;
    logic [1:0] au;
    logic [3:0] act;
    logic [3:0] ok;
    logic lk;
    logic irq;
    logic [1:0] sel;
    logic fl;
    logic lko;
    logic io;
    logic ie;
  } row_s;
  // ************************************
  // Signals
  // ************************************
  logic sys_clk = 1'h0, rst_b = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic fss = 1'h0, pair_sel = 1'h0, pll_lk = 1'h0, irq_ev = 1'h0, drv_en = 1'h0, drv_val = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] act = 4'h0, ok = 4'h0;
  logic [1:0] auto_ix = 2'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, gio_out, gio_oe, gio_in, fail_o, fail_oe, lock_o;
  logic irq_o, irq_oe, irq_line, rate_o, clk5_o;
  logic [1:0] sel_o;
  logic [11:0] base_o;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  row_s r;
  row_s rows [9] = '{
    '{8'h31, 5'h00, 2'h0, 2'h3, 4'hF, 4'hF, 1'h1, 1'h0, 2'h0, 1'h0, 1'h1, 1'h1, 1'h1},
    '{8'h31, 5'h00, 2'h1, 2'h3, 4'hD, 4'hF, 1'h0, 1'h1, 2'h1, 1'h1, 1'h0, 1'h0, 1'h1},
    '{8'h31, 5'h02, 2'h2, 2'h0, 4'hF, 4'hB, 1'h1, 1'h1, 2'h2, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h31, 5'h06, 2'h3, 2'h0, 4'hF, 4'hF, 1'h1, 1'h1, 2'h3, 1'h0, 1'h1, 1'h0, 1'h0},
    '{8'h31, 5'h06, 2'h3, 2'h0, 4'hF, 4'hF, 1'h1, 1'h0, 2'h3, 1'h0, 1'h1, 1'h0, 1'h1},
    '{8'h31, 5'h01, 2'h2, 2'h0, 4'hB, 4'hF, 1'h1, 1'h0, 2'h2, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h31, 5'h07, 2'h2, 2'h0, 4'hF, 4'hF, 1'h1, 1'h0, 2'h2, 1'h0, 1'h1, 1'h0, 1'h1},
    '{8'h10, 5'h18, 2'h3, 2'h2, 4'hF, 4'hF, 1'h1, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1},
    '{8'h20, 5'h08, 2'h0, 2'h1, 4'hF, 4'hD, 1'h1, 1'h1, 2'h1, 1'h1, 1'h1, 1'h1, 1'h1}};
  gcs_top gcs_top_i (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .fast_source_switch_in(fss),
    .general_io_four_in(gio_in), .general_io_four_out(gio_out), .general_io_four_oe_out(gio_oe),
    .ref_active_in(act), .ref_freq_ok_in(ok), .auto_ref_index_in(auto_ix), .pair_sel_in(pair_sel),
    .pll_locked_in(pll_lk), .irq_event_in(irq_ev), .reference_fail_out(fail_o),
    .reference_fail_oe_out(fail_oe), .lock_out(lock_o), .interrupt_request_out(irq_o),
    .interrupt_request_oe_out(irq_oe), .selected_ref_out(sel_o), .rate_family_out(rate_o),
    .base_freq_khz_out(base_o), .clk5_sonet_out(clk5_o));
  gcs_board_model gcs_board_model_i (
    .gio_out_in(gio_out), .gio_oe_in(gio_oe), .drv_en_in(drv_en), .drv_val_in(drv_val),
    .irq_out_in(irq_o), .irq_oe_in(irq_oe), .gio_level_out(gio_in), .irq_level_out(irq_line));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ************************************
  // Tasks
  // ************************************
  task automatic complete_run;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic do_reset(input logic sw, input logic rt);
    rst_b <= 1'h0;
    fss <= sw;
    drv_en <= 1'h1;
    drv_val <= rt;
    repeat (3) @(posedge sys_clk);
    `CHK("in_rst", 5'h0, {pready, gio_oe, fail_oe, lock_o, irq_oe})
    repeat (7) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (6) @(posedge sys_clk);
    drv_en <= 1'h0;
    fss <= ~sw;
    apb(1'h0, gcs_pkg::STRAP_OFS, 32'h0);
    `CHK("strap", {30'h0, rt, sw}, rd)
    apb(1'h0, gcs_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl", {28'h0, rt, rt, rt, sw}, rd)
    apb(1'h0, gcs_pkg::INTPIN_OFS, 32'h0);
    `CHK("intpin", {32'h0, 2'h3}, {rd, irq_o, irq_oe})
    `CHK("rate", {rt, rt, rt ? gcs_pkg::SONET_BASE_KHZ : gcs_pkg::SDH_BASE_KHZ}, {rate_o, clk5_o, base_o})
  endtask : do_reset
  task automatic rd_stat;
    repeat (3) @(posedge sys_clk);
    apb(1'h0, gcs_pkg::STAT_OFS, 32'h0);
  endtask : rd_stat
  // ************************************
  // Sequence
  // ************************************
  initial begin
    do_reset(1'h1, 1'h1);
    do_reset(1'h0, 1'h0);
    do_reset(1'h1, 1'h0);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'h1, gcs_pkg::CTRL_OFS, {24'h0, r.ctl});
      apb(1'h1, gcs_pkg::INTPIN_OFS, {27'h0, r.icf});
      {pair_sel, fss} <= r.ps;
      auto_ix <= r.au;
      act <= r.act;
      ok <= r.ok;
      pll_lk <= r.lk;
      irq_ev <= r.irq;
      repeat (4) @(posedge sys_clk);
      `CHK("sel", r.sel, sel_o)
      `CHK("fail_oe", r.ctl[4], fail_oe)
      if (r.ctl[4]) `CHK("fail", r.fl, fail_o)
      `CHK("lock", r.lko, lock_o)
      `CHK("irq", {r.io, r.ie, r.ie ? r.io : 1'h1}, {irq_o, irq_oe, irq_line})
      apb(1'h0, gcs_pkg::STAT_OFS, 32'h0);
      `CHK("stat", {r.sel, r.act[r.sel], r.lk, r.fl}, rd[5:1])
    end
    apb(1'h1, gcs_pkg::CTRL_OFS, 32'hC0);
    rd_stat();
    `CHK("gp_hi", 3'h7, {gio_oe, gio_out, rd[0]})
    apb(1'h1, gcs_pkg::CTRL_OFS, 32'h40);
    rd_stat();
    `CHK("gp_lo", 3'h4, {gio_oe, gio_out, rd[0]})
    drv_en <= 1'h1;
    drv_val <= 1'h1;
    apb(1'h1, gcs_pkg::CTRL_OFS, 32'h00);
    rd_stat();
    `CHK("gp_in", 2'h1, {gio_oe, rd[0]})
    drv_en <= 1'h0;
    rd_stat();
    `CHK("gp_pd", 1'h0, rd[0])
    apb(1'h1, 8'h10, 32'hFF);
    `CHK("err_wr", 1'h1, er)
    apb(1'h0, 8'h10, 32'h0);
    `CHK("err_rd", {1'h1, 32'h0}, {er, rd})
    apb(1'h1, gcs_pkg::STRAP_OFS, 32'h3);
    `CHK("ro_wr", 1'h0, er)
    apb(1'h0, gcs_pkg::STRAP_OFS, 32'h0);
    `CHK("strap_kept", 32'h1, rd)
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
